// ==== logic/pmc_pkg.sv ====
// Constants and types shared by the power-mode controller
package pmc_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] PMC_PWR_CTRL_IDX = 8'h87;
	localparam logic [7:0] PMC_OSC_CTRL_IDX = 8'h88;
	localparam logic [7:0] PMC_STATUS_IDX = 8'h89;
	localparam logic [7:0] PMC_WAKE_EN_IDX = 8'h8a;

	// Byte address decode
	localparam int PMC_IDX_LSB = 2;
	localparam int PMC_IDX_MSB = 9;
	localparam logic [2:0] PMC_HSIZE_WORD = 3'h2;

	// Power control register fields
	localparam int PMC_IDLE_BIT = 0;
	localparam int PMC_STOP_BIT = 1;
	localparam int PMC_FLAGS_LSB = 2;
	localparam int PMC_FLAGS_MSB = 7;

	// Internal oscillator control register fields
	localparam int PMC_SUSP_BIT = 5;
	localparam int PMC_OSC_HI_LSB = 6;

	// Status register fields
	localparam int PMC_ST_STATE_LSB = 0;
	localparam int PMC_ST_CAUSE_LSB = 4;
	localparam int PMC_ST_IRQ_BIT = 7;

	// Wake source positions
	localparam int PMC_WAKE_N = 3;
	localparam int PMC_WAKE_PMATCH = 0;
	localparam int PMC_WAKE_CMPLOW = 1;
	localparam int PMC_WAKE_TMR3 = 2;

	// Values after reset
	localparam logic [5:0] PMC_FLAGS_RST = 6'h00;
	localparam logic [6:0] PMC_OSC_RST = 7'h00;
	localparam logic [2:0] PMC_WAKE_EN_RST = 3'h0;
	localparam logic [15:0] PMC_RESET_VEC = 16'h0000;

	// Core power states, one-hot
	typedef enum logic [3:0] {
		PMC_RUN = 4'b0001,
		PMC_IDLE = 4'b0010,
		PMC_STOP = 4'b0100,
		PMC_SUSP = 4'b1000
	} pmc_state_t;

endpackage

// ==== logic/pmc_sync3.sv ====
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pmc_sync3 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_q;

	// Shift chain; output moves only when stages two and three agree
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			out_q <= '0;
		end else begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
		end
	end

	assign sync_out = out_q;

endmodule

// ==== logic/pmc_top.sv ====
// Power-mode controller: run, idle, stop and suspend sequencing
`timescale 1ns/1ps
module pmc_top
	import pmc_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic instr_done,
	input wire logic irq_req,
	input wire logic wdt_en,
	input wire logic wdt_expire,
	input wire logic [2:0] wake_pin,
	output logic cpu_clk_en,
	output logic periph_clk_en,
	output logic int_osc_en,
	output logic resume,
	output logic wdt_rst_req,
	output logic fetch_start,
	output logic [15:0] fetch_addr
);

	pmc_state_t state_q, state_d;
	logic idle_q;
	logic stop_q;
	logic susp_q;
	logic [5:0] flags_q;
	logic [1:0] osc_hi_q;
	logic [4:0] osc_lo_q;
	logic [2:0] wake_en_q;
	logic [2:0] cause_q;
	logic irq_woke_q;
	logic ap_wr_q;
	logic ap_rd_q;
	logic [7:0] ap_idx_q;
	logic [31:0] rdata_q;
	logic [31:0] rd_mux;
	logic ap_ok;
	logic wr_pwr;
	logic wr_osc;
	logic wr_wake;
	logic irq_prev_q;
	logic irq_rise;
	logic [2:0] wake_s;
	logic [2:0] wake_prev_q;
	logic [2:0] wake_rise;
	logic wake_hit;
	logic enter_idle;
	logic cpu_clk_en_q;
	logic periph_clk_en_q;
	logic int_osc_en_q;
	logic resume_q;
	logic wdt_rst_req_q;
	logic started_q;
	logic fetch_start_q;
	logic [15:0] fetch_addr_q;

	// Wake sources come from other clock domains
	pmc_sync3 #(
		.W(PMC_WAKE_N)
	) u_wake_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.async_in(wake_pin),
		.sync_out(wake_s)
	);

	// Bus answers at once and never errors
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;

	// Valid word access inside the register window
	assign ap_ok = hsel && htrans[1] && hready &&
		(haddr[31:PMC_IDX_MSB+1] == '0) &&
		(haddr[PMC_IDX_LSB-1:0] == '0) &&
		(hsize == PMC_HSIZE_WORD);

	// Data-phase write strobes
	assign wr_pwr = ap_wr_q && (ap_idx_q == PMC_PWR_CTRL_IDX);
	assign wr_osc = ap_wr_q && (ap_idx_q == PMC_OSC_CTRL_IDX);
	assign wr_wake = ap_wr_q && (ap_idx_q == PMC_WAKE_EN_IDX);

	// Read multiplexer, unmapped indices read zero
	always_comb begin
		rd_mux = '0;
		unique case (haddr[PMC_IDX_MSB:PMC_IDX_LSB])
			PMC_PWR_CTRL_IDX: begin
				rd_mux[PMC_FLAGS_MSB:PMC_FLAGS_LSB] = flags_q;
			end
			PMC_OSC_CTRL_IDX: begin
				rd_mux[7:0] = {osc_hi_q, susp_q, osc_lo_q};
			end
			PMC_STATUS_IDX: begin
				rd_mux[PMC_ST_STATE_LSB +: 4] = state_q;
				rd_mux[PMC_ST_CAUSE_LSB +: 3] = cause_q;
				rd_mux[PMC_ST_IRQ_BIT] = irq_woke_q;
			end
			PMC_WAKE_EN_IDX: rd_mux[PMC_WAKE_N-1:0] = wake_en_q;
			default: rd_mux = '0;
		endcase
	end

	// Address phase capture and read data
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap_wr_q <= 1'b0;
			ap_rd_q <= 1'b0;
			ap_idx_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
		end else begin
			ap_wr_q <= ap_ok && hwrite;
			ap_rd_q <= ap_ok && !hwrite;
			ap_idx_q <= haddr[PMC_IDX_MSB:PMC_IDX_LSB];
			if (ap_ok && !hwrite) begin
				rdata_q <= rd_mux;
			end else begin
				rdata_q <= 32'h0000_0000;
			end
		end
	end

	// Edge detection so that only fresh requests count
	assign irq_rise = irq_req && !irq_prev_q;
	assign wake_rise = wake_s & ~wake_prev_q & wake_en_q;
	assign wake_hit = |wake_rise;
	assign enter_idle = (state_q == PMC_RUN) && instr_done &&
		idle_q && !stop_q && !susp_q;

	// Previous request levels
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_prev_q <= 1'b0;
			wake_prev_q <= 3'h0;
		end else begin
			irq_prev_q <= irq_req;
			wake_prev_q <= wake_s;
		end
	end

	// Mode select bits; a hardware clear loses to a write
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			idle_q <= 1'b0;
			stop_q <= 1'b0;
			susp_q <= 1'b0;
		end else begin
			if (wr_pwr) begin
				idle_q <= hwdata[PMC_IDLE_BIT];
			end else if (state_q == PMC_IDLE && irq_rise) begin
				idle_q <= 1'b0;
			end
			if (wr_pwr) begin
				stop_q <= hwdata[PMC_STOP_BIT];
			end
			if (wr_osc) begin
				susp_q <= hwdata[PMC_SUSP_BIT];
			end else if (state_q == PMC_SUSP && wake_hit) begin
				susp_q <= 1'b0;
			end
		end
	end

	// Software storage registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_q <= PMC_FLAGS_RST;
			osc_hi_q <= PMC_OSC_RST[6:5];
			osc_lo_q <= PMC_OSC_RST[4:0];
			wake_en_q <= PMC_WAKE_EN_RST;
		end else begin
			if (wr_pwr) begin
				flags_q <= hwdata[PMC_FLAGS_MSB:PMC_FLAGS_LSB];
			end
			if (wr_osc) begin
				osc_hi_q <= hwdata[PMC_OSC_HI_LSB +: 2];
				osc_lo_q <= hwdata[PMC_SUSP_BIT-1:0];
			end
			if (wr_wake) begin
				wake_en_q <= hwdata[PMC_WAKE_N-1:0];
			end
		end
	end

	// Next power state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			PMC_RUN: begin
				if (instr_done) begin
					if (stop_q) begin
						state_d = PMC_STOP;
					end else if (susp_q) begin
						state_d = PMC_SUSP;
					end else if (idle_q) begin
						state_d = PMC_IDLE;
					end
				end
			end
			PMC_IDLE: if (irq_rise) begin
				state_d = PMC_RUN;
			end
			PMC_SUSP: if (wake_hit) begin
				state_d = PMC_RUN;
			end
			PMC_STOP: state_d = PMC_STOP;
			default: state_d = PMC_RUN;
		endcase
	end

	// State register; any reset returns to run
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= PMC_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	// Clock and oscillator enables from the coming state
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cpu_clk_en_q <= 1'b1;
			periph_clk_en_q <= 1'b1;
			int_osc_en_q <= 1'b1;
		end else begin
			cpu_clk_en_q <= (state_d == PMC_RUN);
			periph_clk_en_q <= state_d inside {PMC_RUN, PMC_IDLE};
			int_osc_en_q <= state_d inside {PMC_RUN, PMC_IDLE};
		end
	end

	// Resume pulse and wake cause record
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			resume_q <= 1'b0;
			cause_q <= 3'h0;
			irq_woke_q <= 1'b0;
		end else begin
			resume_q <= (state_q == PMC_IDLE && irq_rise) ||
				(state_q == PMC_SUSP && wake_hit);
			if (state_q == PMC_SUSP && wake_hit) begin
				cause_q <= wake_rise;
				irq_woke_q <= 1'b0;
			end else if (state_q == PMC_IDLE && irq_rise) begin
				irq_woke_q <= 1'b1;
			end
		end
	end

	// Watchdog expiry passes on while its clock runs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wdt_rst_req_q <= 1'b0;
		end else begin
			wdt_rst_req_q <= wdt_en && wdt_expire &&
				(state_q == PMC_RUN || state_q == PMC_IDLE);
		end
	end

	// Fetch restart once after reset release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			started_q <= 1'b0;
			fetch_start_q <= 1'b0;
			fetch_addr_q <= PMC_RESET_VEC;
		end else begin
			started_q <= 1'b1;
			fetch_start_q <= !started_q;
			fetch_addr_q <= PMC_RESET_VEC;
		end
	end

	// Registered outputs
	assign cpu_clk_en = cpu_clk_en_q;
	assign periph_clk_en = periph_clk_en_q;
	assign int_osc_en = int_osc_en_q;
	assign resume = resume_q;
	assign wdt_rst_req = wdt_rst_req_q;
	assign fetch_start = fetch_start_q;
	assign fetch_addr = fetch_addr_q;

	// Checks
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_idle_irq;
		state_q == PMC_IDLE && irq_rise && !wr_pwr;
	endsequence
	sequence s_resumed;
		state_q == PMC_RUN && resume && !idle_q;
	endsequence
	sequence s_susp_wake;
		state_q == PMC_SUSP && wake_hit && !wr_osc;
	endsequence
	sequence s_enter_busy;
		enter_idle && irq_req ##1 irq_req [*2];
	endsequence

	idle_entry_a: assert property (
		enter_idle |=> state_q == PMC_IDLE
	) else $error("idle not entered after instruction");
	idle_clocks_a: assert property (
		state_q == PMC_IDLE |-> !cpu_clk_en && periph_clk_en && int_osc_en
	) else $error("wrong clock enables in idle");
	idle_hold_a: assert property (
		state_q == PMC_IDLE && !irq_rise |=> state_q == PMC_IDLE
	) else $error("idle left without interrupt");
	irq_wake_a: assert property (
		s_idle_irq |=> s_resumed ##1 !resume
	) else $error("interrupt wake did not resume once");
	stop_hold_a: assert property (
		state_q == PMC_STOP |=> state_q == PMC_STOP
	) else $error("stop left without reset");
	stop_osc_a: assert property (
		state_q == PMC_STOP |-> !int_osc_en && !cpu_clk_en && !periph_clk_en
	) else $error("clock running in stop");
	read_zero_a: assert property (
		ap_rd_q && ap_idx_q == PMC_PWR_CTRL_IDX |-> hrdata[1:0] == 2'b00
	) else $error("mode select bits read nonzero");
	susp_wake_a: assert property (
		s_susp_wake |=> state_q == PMC_RUN && resume && !susp_q ##1 !resume
	) else $error("suspend wake failed");
	wdt_reset_a: assert property (
		state_q == PMC_IDLE && wdt_en && wdt_expire |=> wdt_rst_req
	) else $error("watchdog reset not requested");
	stale_req_a: assert property (
		s_enter_busy |-> state_q == PMC_IDLE
	) else $error("stale interrupt ended idle");
	reset_fetch_a: assert property (
		fetch_start |-> fetch_addr == PMC_RESET_VEC && cpu_clk_en &&
			$past(fetch_start) == 1'b0
	) else $error("bad fetch restart after reset");

endmodule

// ==== sim/pmc_core_model.sv ====
// Behavioural model of the core, interrupt logic and wake sources
`timescale 1ns/1ps
module pmc_core_model (
	input wire logic clk,
	output logic instr_done,
	output logic irq_req,
	output logic wdt_en,
	output logic wdt_expire,
	output logic [2:0] wake_pin
);
	// Quiet outputs at start
	initial begin
		instr_done = 1'b0;
		irq_req = 1'b0;
		wdt_en = 1'b0;
		wdt_expire = 1'b0;
		wake_pin = 3'h0;
	end
	// Finish the instruction that set a mode bit
	task step();
		@(posedge clk);
		instr_done <= 1'b1;
		@(posedge clk);
		instr_done <= 1'b0;
		@(posedge clk); // Two-byte follower keeps done low
	endtask
	// Interrupt level, settled one edge
	task irq(input logic v);
		@(posedge clk);
		irq_req <= v;
		@(posedge clk);
	endtask
	// Watchdog expiry with enable as software left it
	task wdog(input logic en);
		@(posedge clk);
		wdt_en <= en; // Disabled first to stay idle
		wdt_expire <= 1'b1;
		@(posedge clk);
		wdt_expire <= 1'b0;
		wdt_en <= 1'b0;
	endtask
	// Wake source held well past the input filter
	task wake(input logic [2:0] w);
		@(posedge clk);
		wake_pin <= w;
		repeat (5) @(posedge clk);
		wake_pin <= 3'h0;
	endtask
endmodule

// ==== sim/pmc_top_tb.sv ====
// Self-checking bench for the power-mode controller
`timescale 1ns/1ps
module pmc_top_tb;
	import pmc_pkg::*;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic hreadyout, hresp, cpu_clk_en, periph_clk_en, int_osc_en;
	logic resume, wdt_rst_req, fetch_start, instr_done, irq_req;
	logic wdt_en, wdt_expire;
	logic [2:0] wake_pin;
	logic [15:0] fetch_addr;
	logic [31:0] hrdata, obs, flags, got, want;
	logic rd_ph = 1'b0;
	logic sn = 1'b0;
	logic [31:0] exp_q[$];
	int num_errors = 0;
	int check_count = 0;

	// Clock and output snapshot
	always #10 hclk = ~hclk;
	assign obs = {fetch_addr, 9'h0, hresp, resume, wdt_rst_req, fetch_start,
		cpu_clk_en, periph_clk_en, int_osc_en};

	pmc_top pmc_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
		.hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
		.instr_done, .irq_req, .wdt_en, .wdt_expire, .wake_pin, .cpu_clk_en,
		.periph_clk_en, .int_osc_en, .resume, .wdt_rst_req, .fetch_start,
		.fetch_addr);
	pmc_core_model core_i (.clk(hclk), .instr_done, .irq_req, .wdt_en,
		.wdt_expire, .wake_pin);

	task fail(input logic [31:0] g, input logic [31:0] w);
		num_errors++;
		$display("wrong value at %0t: got %h expected %h", $time, g, w);
	endtask
	task wrap_up();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Compare the oldest note with read data or the snapshot
	always @(posedge hclk) begin
		if (rd_ph || sn) begin
			got = rd_ph ? hrdata : obs;
			want = exp_q.pop_front();
			check_count++;
			if (got !== want)
				fail(got, want);
		end
	end

	task wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < 20);
		if (n >= 20) begin
			fail(32'h0, 32'h1);
			wrap_up();
		end
	endtask
	// One single AHB transfer; on reads d is the expected data
	task bus(input logic wr, input logic [7:0] idx, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {22'h0, idx, 2'h0};
		hwrite <= wr;
		hsize <= PMC_HSIZE_WORD;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		if (!wr) begin
			exp_q.push_back(d);
			rd_ph <= 1'b1;
		end
		wait_rdy();
		rd_ph <= 1'b0;
	endtask
	// Write the slave must ignore: bad size, address or select
	task stray(input logic s, input logic [31:0] a, input logic [2:0] z);
		@(posedge hclk);
		hsel <= s;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= 1'b1;
		hsize <= z;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= 32'hff;
		wait_rdy();
	endtask
	task snap(input logic [31:0] e);
		exp_q.push_back(e);
		sn <= 1'b1;
		@(posedge hclk);
		sn <= 1'b0;
	endtask
	task rst();
		@(posedge hclk);
		hresetn <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
	endtask
	task wait_resume();
		int n;
		n = 0;
		while (resume !== 1'b1 && n < 30) begin
			@(negedge hclk);
			n++;
		end
		check_count++;
		if (n >= 30) begin
			fail({31'h0, resume}, 32'h1);
			wrap_up();
		end
		@(posedge hclk);
	endtask

	// Main sequence
	initial begin
		void'($urandom(24471));
		rst();
		snap(32'h0f);
		bus(0, PMC_STATUS_IDX, 32'h01);
		bus(1, PMC_STATUS_IDX, 32'hff);
		bus(0, PMC_STATUS_IDX, 32'h01);
		bus(0, 8'h90, 32'h0);
		bus(1, PMC_OSC_CTRL_IDX, 32'h1f);
		bus(0, PMC_OSC_CTRL_IDX, 32'h1f);
		for (int i = 0; i < 3; i++) begin
			bus(1, PMC_WAKE_EN_IDX, 32'h1 << i);
			bus(1, PMC_OSC_CTRL_IDX, 32'h20);
			core_i.step();
			snap(32'h0);
			fork
				core_i.wake(3'h1 << i);
				wait_resume();
			join
			bus(0, PMC_STATUS_IDX, 32'h01 | (32'h10 << i));
		end
		bus(0, PMC_OSC_CTRL_IDX, 32'h0);
		flags = $urandom & 32'hfc;
		core_i.irq(1);
		bus(1, PMC_PWR_CTRL_IDX, flags | 32'h1);
		bus(0, PMC_PWR_CTRL_IDX, flags);
		core_i.step();
		snap(32'h03);
		core_i.wdog(0);
		snap(32'h03);
		core_i.wdog(1);
		snap(32'h13);
		core_i.irq(0);
		core_i.irq(1);
		snap(32'h27);
		bus(0, PMC_PWR_CTRL_IDX, flags);
		stray(1'b1, 32'h21c, 3'($urandom % 2));
		stray(1'b1, 32'h61c, PMC_HSIZE_WORD);
		stray(1'b0, 32'h21c, PMC_HSIZE_WORD);
		bus(0, PMC_PWR_CTRL_IDX, flags);
		bus(1, PMC_PWR_CTRL_IDX, 32'h2);
		core_i.step();
		snap(32'h0);
		core_i.irq(0);
		core_i.irq(1);
		snap(32'h0);
		rst();
		snap(32'h0f);
		bus(0, PMC_PWR_CTRL_IDX, 32'h0);
		wrap_up();
	end
endmodule
